/* src/near_speed_status.sv */
// Positioning near flag and torque-mode speed limit status
// Notes on behaviour
// - Near flag when error below near width
// - Near flag drives pin only when assigned
// - Limit output active while cap is applied
// - Limit flag drives pin only when assigned
// - Torque mode speed is bounded by cap
// - Source select latched at restart: internal/host
// - Internal cap setting 0..10000, immediate
// - Reference select latched at restart: max/overspeed
// - Setting above motor max uses reference
// - Host cap honoured in external mode
`default_nettype none
module near_speed_status #(
	parameter int POS_W = near_limit_pkg::POS_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Position tracking
	input wire logic [POS_W-1:0] ref_count,
	input wire logic [POS_W-1:0] travel_count,
	input wire logic [30:0] near_width_setting,
	input wire logic near_output_assignment,
	// Speed limit configuration
	input wire logic torque_mode,
	input wire logic limit_source_select,
	input wire logic cap_reference_select,
	input wire logic limit_output_assignment,
	input wire logic [15:0] torque_mode_speed_cap,
	input wire logic [15:0] host_speed_cap,
	input wire logic [15:0] motor_max_speed,
	input wire logic [15:0] overspeed_level,
	// Motor speed and torque command
	input wire logic [15:0] motor_speed,
	input wire logic torque_cmd_in,
	// Status outputs
	output logic near_flag,
	output logic near_out,
	output logic speed_limit_active,
	output logic limit_out,
	output logic [15:0] applied_cap,
	output logic torque_enable
);
	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	logic [1:0] rst_sync_ff;
	logic rst_n;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// Restart-time selects caught once after reset release
	logic src_sel_ff;
	logic ref_sel_ff;
	logic latched_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_sel_ff <= near_limit_pkg::LIMIT_SRC_INTERNAL;
			ref_sel_ff <= near_limit_pkg::CAP_REF_MOTOR_MAX;
			latched_ff <= 1'h0;
		end else if (clk_en && !latched_ff) begin
			src_sel_ff <= limit_source_select;
			ref_sel_ff <= cap_reference_select;
			latched_ff <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Near detection
	logic signed [POS_W:0] pos_err;
	logic [POS_W:0] abs_err;
	logic [POS_W:0] width_ext;
	logic [POS_W:0] width_clamped;
	logic nxt_near;
	logic near_ff;

	always_comb begin
		pos_err = $signed({ref_count[POS_W-1], ref_count}) - $signed({travel_count[POS_W-1], travel_count});
		abs_err = pos_err[POS_W] ? (POS_W+1)'(-pos_err) : pos_err;
		width_ext = (POS_W+1)'(near_width_setting);
		// Out-of-range setting clamped to the top of the range
		width_clamped = (near_width_setting > near_limit_pkg::NEAR_WIDTH_MAX) ?
			(POS_W+1)'(near_limit_pkg::NEAR_WIDTH_MAX) : width_ext;
		nxt_near = abs_err < width_clamped;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			near_ff <= 1'h0;
		end else if (clk_en) begin
			near_ff <= nxt_near;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			near_out <= 1'h0;
		end else if (clk_en) begin
			near_out <= nxt_near & near_output_assignment;
		end
	end
	assign near_flag = near_ff;

	////////////////////////////////////////////////////////////////////////
	// Cap selection
	cap_if cif ();
	logic [15:0] setting_clamped;

	// Setting above its range behaves as range top
	assign setting_clamped = (torque_mode_speed_cap > near_limit_pkg::CAP_SETTING_MAX) ?
		near_limit_pkg::CAP_SETTING_MAX : torque_mode_speed_cap;
	assign cif.motor_max = motor_max_speed;
	assign cif.overspeed = overspeed_level;
	assign cif.cap_setting = setting_clamped;
	assign cif.host_cap = host_speed_cap;
	assign cif.src_sel = src_sel_ff;
	assign cif.ref_sel = ref_sel_ff;

	cap_select u_cap_select (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.cif(cif.sel)
	);
	assign applied_cap = cif.cap;

	////////////////////////////////////////////////////////////////////////
	// Limit state: speed at or over cap in torque mode
	near_limit_pkg::lim_state_t state_ff;
	near_limit_pkg::lim_state_t nxt_state;
	logic at_cap;

	assign at_cap = torque_mode && (motor_speed >= cif.cap);

	always_comb begin
		case (state_ff)
			near_limit_pkg::LIM_IDLE: begin
				nxt_state = at_cap ? near_limit_pkg::LIM_ACTIVE : near_limit_pkg::LIM_IDLE;
			end
			near_limit_pkg::LIM_ACTIVE: begin
				nxt_state = at_cap ? near_limit_pkg::LIM_ACTIVE : near_limit_pkg::LIM_IDLE;
			end
			default: begin
				nxt_state = near_limit_pkg::LIM_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= near_limit_pkg::LIM_IDLE;
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			limit_out <= 1'h0;
		end else if (clk_en) begin
			limit_out <= (nxt_state == near_limit_pkg::LIM_ACTIVE) & limit_output_assignment;
		end
	end
	assign speed_limit_active = (state_ff == near_limit_pkg::LIM_ACTIVE);

	////////////////////////////////////////////////////////////////////////
	// Torque gate: drive torque withheld while speed is at cap
	// Simple bang-bang bound; real loop would taper torque instead
	assign torque_enable = torque_cmd_in & ~(torque_mode & at_cap);
endmodule : near_speed_status
`default_nettype wire

/* shared/near_limit_pkg.sv */
// Package: constants and types for the near and speed limit status block
`default_nettype none
package near_limit_pkg;
	localparam int POS_W = 32;
	localparam int SPD_W = 16;
	localparam logic [30:0] NEAR_WIDTH_MAX = 31'h40000000;
	localparam logic [30:0] NEAR_WIDTH_RST = 31'h40000000;
	localparam logic [15:0] CAP_SETTING_MAX = 16'h2710;
	localparam logic [15:0] CAP_SETTING_RST = 16'h2710;
	localparam logic LIMIT_SRC_INTERNAL = 1'h0;
	localparam logic LIMIT_SRC_HOST = 1'h1;
	localparam logic CAP_REF_MOTOR_MAX = 1'h0;
	localparam logic CAP_REF_OVERSPEED = 1'h1;
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {
		LIM_IDLE = 2'h0,
		LIM_ACTIVE = 2'h1
	} lim_state_t;
endpackage : near_limit_pkg
`default_nettype wire

/* shared/cap_if.sv */
// Interface: speed cap candidates and resolved cap between main and cap selector
`default_nettype none
interface cap_if;
	logic [15:0] motor_max;
	logic [15:0] overspeed;
	logic [15:0] cap_setting;
	logic [15:0] host_cap;
	logic src_sel;
	logic ref_sel;
	logic [15:0] cap;
	modport main (output motor_max, output overspeed, output cap_setting, output host_cap,
		output src_sel, output ref_sel, input cap);
	modport sel (input motor_max, input overspeed, input cap_setting, input host_cap,
		input src_sel, input ref_sel, output cap);
endinterface : cap_if
`default_nettype wire

/* src/cap_select.sv */
// Speed cap selector with registered result
`default_nettype none
module cap_select (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Cap candidates
	cap_if.sel cif
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction : min16

	logic [15:0] ref_spd;
	logic [15:0] internal_cap;
	logic [15:0] nxt_cap;
	logic [15:0] cap_ff;

	always_comb begin
		ref_spd = (cif.ref_sel == near_limit_pkg::CAP_REF_OVERSPEED) ? cif.overspeed : cif.motor_max;
		// Setting above motor maximum falls back to chosen reference
		if (cif.cap_setting > cif.motor_max) begin
			internal_cap = ref_spd;
		end else begin
			internal_cap = min16(ref_spd, cif.cap_setting);
		end
		nxt_cap = (cif.src_sel == near_limit_pkg::LIMIT_SRC_HOST) ? cif.host_cap : internal_cap;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_ff <= near_limit_pkg::CAP_SETTING_RST;
		end else if (clk_en) begin
			cap_ff <= nxt_cap;
		end
	end

	assign cif.cap = cap_ff;
endmodule : cap_select
`default_nettype wire

/* tb/host_ctrl_model.sv */
// Host controller model: supplies the external speed limit value
`default_nettype none
module host_ctrl_model (
	// Clock and limit value
	input wire logic ref_clk,
	input wire logic [15:0] cap_req,
	output logic [15:0] host_speed_cap
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered: a host only updates on its own cycle
	always_ff @(posedge ref_clk) host_speed_cap <= cap_req;
endmodule : host_ctrl_model
`default_nettype wire

/* tb/near_speed_status_checker.sv */
// Checker: properties on the status block ports
`default_nettype none
module near_speed_status_checker (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Position tracking
	input wire logic [31:0] ref_count,
	input wire logic [31:0] travel_count,
	input wire logic [30:0] near_width_setting,
	input wire logic near_output_assignment,
	// Speed limit configuration
	input wire logic torque_mode,
	input wire logic limit_source_select,
	input wire logic cap_reference_select,
	input wire logic limit_output_assignment,
	input wire logic [15:0] torque_mode_speed_cap,
	input wire logic [15:0] host_speed_cap,
	input wire logic [15:0] motor_max_speed,
	input wire logic [15:0] overspeed_level,
	// Motor speed and torque command
	input wire logic [15:0] motor_speed,
	input wire logic torque_cmd_in,
	// Status outputs of the block
	input wire logic near_flag,
	input wire logic near_out,
	input wire logic speed_limit_active,
	input wire logic limit_out,
	input wire logic [15:0] applied_cap,
	input wire logic torque_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] up_ff;
	logic src_ff, ref_ff, ok, near_c, at_cap;
	logic [31:0] err, mag;
	logic [30:0] nw;
	logic [15:0] set_c, refv, exp_cap;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	// Mirrors the two-flop release, then the select latch
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) up_ff <= 2'h0;
		else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
	end
	always_ff @(posedge ref_clk) begin
		if (up_ff == 2'h2) {src_ff, ref_ff} <= {limit_source_select, cap_reference_select};
	end
	assign ok = up_ff == 2'h3;
	assign err = ref_count - travel_count;
	assign mag = err[31] ? -err : err;
	assign nw = near_width_setting > near_limit_pkg::NEAR_WIDTH_MAX ? near_limit_pkg::NEAR_WIDTH_MAX : near_width_setting;
	assign near_c = mag < {1'h0, nw};
	assign set_c = torque_mode_speed_cap > near_limit_pkg::CAP_SETTING_MAX ?
		near_limit_pkg::CAP_SETTING_MAX : torque_mode_speed_cap;
	assign refv = ref_ff ? overspeed_level : motor_max_speed;
	assign exp_cap = src_ff ? host_speed_cap : (set_c > motor_max_speed || refv < set_c) ? refv : set_c;
	assign at_cap = torque_mode && motor_speed >= applied_cap;
	sequence live;
		ok && $past(ok) && $past(clk_en);
	endsequence
	////////////////////////////////////////
	AST_NEAR: assert property (live |-> near_flag == $past(near_c))
		else $error("near flag wrong");
	AST_NEAR_PIN: assert property (live |-> near_out == (near_flag && $past(near_output_assignment)))
		else $error("near pin wrong");
	AST_LIM: assert property (live |-> speed_limit_active == $past(at_cap))
		else $error("limit flag wrong");
	AST_LIM_PIN: assert property (live |-> limit_out == (speed_limit_active && $past(limit_output_assignment)))
		else $error("limit pin wrong");
	AST_GATE: assert property (torque_enable == (torque_cmd_in && !at_cap))
		else $error("torque gate wrong");
	AST_CAP: assert property (live |-> applied_cap == $past(exp_cap))
		else $error("applied cap wrong");
	AST_IDLE: assert property (ok && $past(ok) && $past(clk_en) && !$past(torque_mode)
		|-> !speed_limit_active && !limit_out)
		else $error("limit outside torque mode");
	AST_FREEZE: assert property (ok && $past(ok) && !$past(clk_en)
		|-> $stable(applied_cap) && $stable(near_flag))
		else $error("state moved while frozen");
	cover property (near_out);
	cover property (limit_out && !torque_enable);
	cover property (ok && src_ff);
endmodule : near_speed_status_checker
bind near_speed_status near_speed_status_checker u_chk (.*);
`default_nettype wire

/* tb/near_speed_status_bench.sv */
// Testbench: scenarios for the near and speed limit status block
`default_nettype none
module near_speed_status_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0, nrst = 1'h0, clk_en = 1'h1, torque_mode = 1'h0, torque_cmd_in = 1'h1;
	logic limit_source_select = 1'h0, cap_reference_select = 1'h0;
	logic near_output_assignment = 1'h1, limit_output_assignment = 1'h1;
	logic [31:0] ref_count = 32'h0, travel_count = 32'h0;
	logic [30:0] near_width_setting = 31'h0;
	logic [15:0] torque_mode_speed_cap = 16'h0, cap_req = 16'h0, motor_max_speed = 16'h0;
	logic [15:0] overspeed_level = 16'h0, motor_speed = 16'h0, host_speed_cap, applied_cap;
	logic near_flag, near_out, speed_limit_active, limit_out, torque_enable;
	int failures = 0, num_checks = 0, cyc = 0;
	always #2 ref_clk = ~ref_clk;
	near_speed_status u_near_speed_status (.*);
	host_ctrl_model u_host_ctrl_model (.*);
	////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Four edges cover host register, cap and limit stages
	task automatic wt;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : wt
	task automatic do_reset(input logic s, r);
		@(posedge ref_clk);
		nrst <= 1'h0;
		{limit_source_select, cap_reference_select} <= {s, r};
		// Five cycles low counting the release edge
		repeat (4) @(posedge ref_clk);
		#1 chk("rst_cap", near_limit_pkg::CAP_SETTING_RST, applied_cap);
		chk("rst_near", 16'h0, near_flag);
		@(posedge ref_clk);
		nrst <= 1'h1;
		wt();
	endtask : do_reset
	task automatic t_near;
		@(posedge ref_clk);
		{ref_count, travel_count, near_width_setting} <= {32'h64, 32'h5A, 31'h14};
		wt();
		chk("near", 16'h1, near_out);
		@(posedge ref_clk);
		{travel_count, near_output_assignment} <= {32'h6E, 1'h0};
		wt();
		chk("near_neg", 16'h1, near_flag);
		chk("near_unassigned", 16'h0, near_out);
		@(posedge ref_clk);
		near_width_setting <= 31'hA;
		wt();
		chk("near_edge", 16'h0, near_flag);
		@(posedge ref_clk);
		{clk_en, near_width_setting} <= {1'h0, 31'h40000000};
		wt();
		chk("near_frozen", 16'h0, near_flag);
		@(posedge ref_clk);
		clk_en <= 1'h1;
		wt();
		chk("near_max", 16'h1, near_flag);
	endtask : t_near
	task automatic t_lim;
		@(posedge ref_clk);
		{motor_max_speed, overspeed_level, torque_mode_speed_cap} <= {16'h2EE0, 16'h32C8, 16'h4E20};
		wt();
		chk("cap_clamp", 16'h2710, applied_cap);
		@(posedge ref_clk);
		{torque_mode_speed_cap, motor_max_speed, motor_speed, torque_mode} <= {16'h07D0, 16'h0BB8, 16'h07D0, 1'h1};
		wt();
		chk("cap_min", 16'h07D0, applied_cap);
		chk("lim", 16'h1, limit_out);
		chk("gate", 16'h0, torque_enable);
		@(posedge ref_clk);
		{torque_mode_speed_cap, limit_output_assignment} <= {16'h1388, 1'h0};
		wt();
		chk("cap_ref", 16'h0BB8, applied_cap);
		chk("lim_below", 16'h0, speed_limit_active);
		@(posedge ref_clk);
		motor_speed <= 16'h0BB8;
		wt();
		chk("lim_act", 16'h1, speed_limit_active);
		chk("lim_unassigned", 16'h0, limit_out);
		@(posedge ref_clk);
		torque_mode <= 1'h0;
		wt();
		chk("lim_mode", 16'h0, speed_limit_active);
	endtask : t_lim
	task automatic t_host;
		do_reset(1'h1, 1'h0);
		@(posedge ref_clk);
		{cap_req, limit_source_select} <= {16'h01F4, 1'h0};
		wt();
		chk("cap_host", 16'h01F4, applied_cap);
		do_reset(1'h0, 1'h1);
		chk("cap_ovs", 16'h32C8, applied_cap);
	endtask : t_host
	task automatic print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 1000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		do_reset(1'h0, 1'h0);
		t_near();
		t_lim();
		t_host();
		print_verdict();
	end
endmodule : near_speed_status_bench
`default_nettype wire
